// file: inc/crb_consts.svh
`ifndef CRB_CONSTS_SVH
`define CRB_CONSTS_SVH

// register command codes
`define REG_SW_CTRL   8'hd0
`define REG_CC_LIMIT  8'hd1
`define REG_LDC       8'hd2
`define REG_SLEW      8'hd3
`define REG_ADDR_CTRL 8'hd4
`define REG_MASK      8'hd8
`define REG_CFG_CODE  8'hd9
`define REG_REV       8'hda
`define CMD_THERMAL   8'h7d
`define CMD_CLEAR     8'h03
`define REG_COUNT     11

// reset values held until the nvm image is loaded
`define RST_SW_CTRL   8'h2f
`define RST_CC_LIMIT  8'h6c
`define RST_ADDR_CTRL 8'h07

// field positions
`define ADDR_FIXED    2'b11
`define OT_BIT        7
`define MASK_OT_BIT   7
`define DIS_BIT       1
`define LDC_OFF_BIT   7

// current limit: 50 mA per code, clamp at 5400 mA
`define CC_STEP_MA    50
`define CC_MAX_MA     5400

// timing
`define CLK_KHZ       200000
`define DISCHARGE_MS  200

`endif

// file: inc/crb_pkg.sv
`default_nettype none
package crb_pkg;

	typedef struct packed {
		logic       spread_spectrum_on;
		logic [1:0] switching_rate_select;
		logic [1:0] external_fet_resistance_code;
		logic       overvoltage_protect_on;
		logic       discharge_on;
		logic       forced_pulse_width_select;
	} crb_sw_ctrl_t;

	typedef struct packed {
		logic [7:0] sw_ctrl;
		logic [7:0] cc_limit;
		logic [7:0] ldc;
		logic [7:0] slew;
		logic [7:0] addr_ctrl;
		logic [7:0] mask;
		logic [7:0] cfg_code;
		logic [7:0] rev;
	} crb_otp_t;

	typedef enum logic [2:0] {
		ST_IDLE, ST_ADDR, ST_ACK_A, ST_WDATA, ST_ACK_W, ST_RDATA, ST_ACK_R
	} crb_i2c_st_t;

endpackage : crb_pkg
`default_nettype wire

// file: verilog/crb_i2c_slave.sv
`timescale 1ns/1ps
`default_nettype none
module crb_i2c_slave
	import crb_pkg::*;
(
	input  wire logic       clk_in,
	input  wire logic       rst_in,
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	input  wire logic [6:0] dev_addr_in,
	input  wire logic [7:0] rd_data_in,
	output logic            sda_oe_out,
	output logic            wr_valid_out,
	output logic            wr_first_out,
	output logic            rd_req_out,
	output logic [7:0]      wr_data_out
);
	logic [2:0]  scl_q;
	logic [2:0]  sda_q;
	crb_i2c_st_t st_q;
	logic [3:0]  cnt_q;
	logic [7:0]  sh_q;
	logic        rw_q;
	logic        first_q;
	logic        start_c;
	logic        stop_c;
	logic        rise_c;
	logic        fall_c;

	// stage 0 feeds only stage 1; edges are taken from stages 1 and 2
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			scl_q <= 3'h7;
			sda_q <= 3'h7;
		end else begin
			scl_q <= {scl_q[1:0], scl_in};
			sda_q <= {sda_q[1:0], sda_in};
		end
	end

	assign start_c = scl_q[1] & scl_q[2] & sda_q[2] & ~sda_q[1];
	assign stop_c  = scl_q[1] & scl_q[2] & ~sda_q[2] & sda_q[1];
	assign rise_c  = scl_q[1] & ~scl_q[2];
	assign fall_c  = ~scl_q[1] & scl_q[2];

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			st_q         <= ST_IDLE;
			cnt_q        <= 4'h0;
			sh_q         <= 8'h00;
			rw_q         <= 1'b0;
			first_q      <= 1'b0;
			sda_oe_out   <= 1'b0;
			wr_valid_out <= 1'b0;
			wr_first_out <= 1'b0;
			rd_req_out   <= 1'b0;
			wr_data_out  <= 8'h00;
		end else begin
			wr_valid_out <= 1'b0;
			rd_req_out   <= 1'b0;
			if (stop_c) begin
				st_q       <= ST_IDLE;
				sda_oe_out <= 1'b0;
			end else if (start_c) begin
				st_q       <= ST_ADDR;
				cnt_q      <= 4'h0;
				sda_oe_out <= 1'b0;
			end else begin
				unique case (st_q)
					ST_IDLE: ;
					ST_ADDR, ST_WDATA: begin
						if (rise_c) begin
							sh_q  <= {sh_q[6:0], sda_q[1]};
							cnt_q <= cnt_q + 4'h1;
						end else if (fall_c && cnt_q == 4'h8) begin
							cnt_q <= 4'h0;
							if (st_q == ST_ADDR) begin
								if (sh_q[7:1] == dev_addr_in) begin
									sda_oe_out <= 1'b1;
									rw_q       <= sh_q[0];
									first_q    <= 1'b1;
									rd_req_out <= sh_q[0];
									st_q       <= ST_ACK_A;
								end else begin
									st_q <= ST_IDLE;
								end
							end else begin
								sda_oe_out   <= 1'b1;
								wr_valid_out <= 1'b1;
								wr_data_out  <= sh_q;
								wr_first_out <= first_q;
								first_q      <= 1'b0;
								st_q         <= ST_ACK_W;
							end
						end
					end
					ST_ACK_A, ST_ACK_W: begin
						if (fall_c) begin
							if (rw_q && st_q == ST_ACK_A) begin
								sh_q       <= rd_data_in;
								sda_oe_out <= ~rd_data_in[7];
								st_q       <= ST_RDATA;
							end else begin
								sda_oe_out <= 1'b0;
								st_q       <= ST_WDATA;
							end
						end
					end
					ST_RDATA: begin
						if (rise_c) begin
							cnt_q <= cnt_q + 4'h1;
						end else if (fall_c) begin
							if (cnt_q == 4'h8) begin
								sda_oe_out <= 1'b0;
								cnt_q      <= 4'h0;
								st_q       <= ST_ACK_R;
							end else begin
								sh_q       <= {sh_q[6:0], 1'b0};
								sda_oe_out <= ~sh_q[6];
							end
						end
					end
					ST_ACK_R: begin
						// a nack ends the read; the master then stops
						if (rise_c) begin
							if (sda_q[1]) begin
								st_q <= ST_IDLE;
							end else begin
								rd_req_out <= 1'b1;
							end
						end else if (fall_c) begin
							sh_q       <= rd_data_in;
							sda_oe_out <= ~rd_data_in[7];
							st_q       <= ST_RDATA;
						end
					end
				endcase
			end
		end
	end
endmodule : crb_i2c_slave
`default_nettype wire

// file: verilog/crb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "crb_consts.svh"
module crb_top
	import crb_pkg::*;
#(
	parameter int DISCHARGE_CYCLES = `DISCHARGE_MS * `CLK_KHZ
)(
	input  wire logic       clk_in,
	input  wire logic       rst_in,
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe_out,
	input  wire crb_otp_t   otp_in,
	input  wire logic       overheat_in,
	input  wire logic       shutdown_in,
	input  wire logic       vout_low_in,
	output crb_sw_ctrl_t    sw_ctrl_out,
	output logic [6:0]      cc_threshold_code_value_out,
	output logic [1:0]      line_drop_setting_out,
	output logic [7:0]      slew_ctrl_out,
	output logic [7:0]      blank_ctrl_out,
	output logic            discharge_on_out,
	output logic            alert_output_n_out
);
	localparam logic [3:0] I_SW   = 4'(`REG_SW_CTRL);
	localparam logic [3:0] I_CC   = 4'(`REG_CC_LIMIT);
	localparam logic [3:0] I_LDC  = 4'(`REG_LDC);
	localparam logic [3:0] I_SLEW = 4'(`REG_SLEW);
	localparam logic [3:0] I_ADDR = 4'(`REG_ADDR_CTRL);
	localparam logic [3:0] I_MASK = 4'(`REG_MASK);
	localparam logic [3:0] I_CFG  = 4'(`REG_CFG_CODE);
	localparam logic [3:0] I_REV  = 4'(`REG_REV);
	localparam logic [6:0] CC_MAX = 7'(`CC_MAX_MA / `CC_STEP_MA);
	localparam logic [25:0] DIS_LAST = 26'(DISCHARGE_CYCLES - 1);

	if (DISCHARGE_CYCLES < 1 || DISCHARGE_CYCLES > 2**26) begin : g_chk
		$error("DISCHARGE_CYCLES does not fit the 26-bit timer");
	end

	logic [7:0]  regs_q [0:`REG_COUNT-1];
	logic        loaded_q;
	logic [7:0]  cmd_q;
	logic        clear_q;
	logic [1:0]  ot_q;
	logic [2:0]  sd_q;
	logic [1:0]  vlow_q;
	logic        ot_flag_q;
	logic        ot_flag_d;
	logic [7:0]  rd_data_q;
	logic [6:0]  cc_q;
	logic [1:0]  ldc_q;
	logic        dis_q;
	logic [25:0] dis_cnt_q;
	logic        alert_n_q;
	logic [6:0]  dev_addr;
	logic        wr_valid;
	logic        wr_first;
	logic        rd_req;
	logic [7:0]  wr_data;
	logic        wr_en;
	logic        shut_rise;
	logic [7:0]  sw_byte;
	logic [7:0]  lim_byte;
	logic [7:0]  ldc_byte;

	function automatic logic reg_hit(input logic [7:0] a);
		return (a >= `REG_SW_CTRL && a <= `REG_ADDR_CTRL) ||
			(a >= `REG_MASK && a <= `REG_REV);
	endfunction : reg_hit

	function automatic logic [6:0] clamp_cc(input logic [7:0] v);
		return (v[6:0] > CC_MAX) ? CC_MAX : v[6:0];
	endfunction : clamp_cc

	// external levels are two-stage synchronised before use
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			ot_q   <= 2'h0;
			sd_q   <= 3'h0;
			vlow_q <= 2'h0;
		end else begin
			ot_q   <= {ot_q[0], overheat_in};
			sd_q   <= {sd_q[1:0], shutdown_in};
			vlow_q <= {vlow_q[0], vout_low_in};
		end
	end

	assign dev_addr  = {`ADDR_FIXED, regs_q[I_ADDR][4:0]};
	assign wr_en     = wr_valid & ~wr_first & loaded_q & reg_hit(cmd_q);
	assign shut_rise = sd_q[1] & ~sd_q[2];
	assign sw_byte   = regs_q[I_SW];
	assign lim_byte  = regs_q[I_CC];
	assign ldc_byte  = regs_q[I_LDC];

	crb_i2c_slave u_i2c (
		.clk_in       (clk_in),
		.rst_in       (rst_in),
		.scl_in       (scl_in),
		.sda_in       (sda_in),
		.dev_addr_in  (dev_addr),
		.rd_data_in   (rd_data_q),
		.sda_oe_out   (sda_oe_out),
		.wr_valid_out (wr_valid),
		.wr_first_out (wr_first),
		.rd_req_out   (rd_req),
		.wr_data_out  (wr_data)
	);

	// open drain: the pin is only ever pulled low
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			sda_out <= 1'b0;
		end else begin
			sda_out <= 1'b0;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			loaded_q <= 1'b0;
		end else begin
			loaded_q <= 1'b1;
		end
	end

	// constants hold only during reset; the nvm image lands one cycle later
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			for (int i = 0; i < `REG_COUNT; i++) begin
				regs_q[i] <= 8'h00;
			end
			regs_q[I_SW]   <= `RST_SW_CTRL;
			regs_q[I_CC]   <= `RST_CC_LIMIT;
			regs_q[I_ADDR] <= `RST_ADDR_CTRL;
		end else if (!loaded_q) begin
			regs_q[I_SW]   <= otp_in.sw_ctrl;
			regs_q[I_CC]   <= otp_in.cc_limit;
			regs_q[I_LDC]  <= otp_in.ldc;
			regs_q[I_SLEW] <= otp_in.slew;
			regs_q[I_ADDR] <= otp_in.addr_ctrl;
			regs_q[I_MASK] <= otp_in.mask;
			regs_q[I_CFG]  <= otp_in.cfg_code;
			regs_q[I_REV]  <= otp_in.rev;
		end else if (wr_en) begin
			regs_q[cmd_q[3:0]] <= wr_data;
		end
	end

	// first byte after the address is the command code
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			cmd_q   <= 8'h00;
			clear_q <= 1'b0;
		end else begin
			clear_q <= wr_valid & wr_first & (wr_data == `CMD_CLEAR);
			if (wr_valid && wr_first) begin
				cmd_q <= wr_data;
			end
		end
	end

	// set wins over clear, so a fault still present re-latches at once
	assign ot_flag_d = ot_q[1] | (ot_flag_q & ~clear_q);

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			ot_flag_q <= 1'b0;
			alert_n_q <= 1'b1;
		end else begin
			ot_flag_q <= ot_flag_d;
			alert_n_q <= ~(ot_flag_d & ~regs_q[I_MASK][`MASK_OT_BIT]);
		end
	end

	// unmapped commands read as zero
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			rd_data_q <= 8'h00;
		end else if (rd_req) begin
			if (cmd_q == `CMD_THERMAL) begin
				rd_data_q <= 8'(ot_flag_q) << `OT_BIT;
			end else if (reg_hit(cmd_q)) begin
				rd_data_q <= regs_q[cmd_q[3:0]];
			end else begin
				rd_data_q <= 8'h00;
			end
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			cc_q  <= CC_MAX;
			ldc_q <= 2'h0;
		end else begin
			cc_q  <= clamp_cc(lim_byte);
			ldc_q <= lim_byte[`LDC_OFF_BIT] ? 2'h0 : ldc_byte[1:0];
		end
	end

	// the timer bounds discharge when the output never reaches 50 mV
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			dis_q     <= 1'b0;
			dis_cnt_q <= 26'h0;
		end else if (!sw_byte[`DIS_BIT]) begin
			dis_q     <= 1'b0;
			dis_cnt_q <= 26'h0;
		end else if (shut_rise && !vlow_q[1]) begin
			dis_q     <= 1'b1;
			dis_cnt_q <= 26'h0;
		end else if (dis_q && (vlow_q[1] || dis_cnt_q == DIS_LAST)) begin
			dis_q     <= 1'b0;
			dis_cnt_q <= 26'h0;
		end else if (dis_q) begin
			dis_cnt_q <= dis_cnt_q + 26'h1;
		end
	end

	assign sw_ctrl_out                 = crb_sw_ctrl_t'(sw_byte);
	assign cc_threshold_code_value_out = cc_q;
	assign line_drop_setting_out       = ldc_q;
	assign slew_ctrl_out               = regs_q[I_SLEW];
	assign blank_ctrl_out              = regs_q[I_ADDR];
	assign discharge_on_out            = dis_q;
	assign alert_output_n_out          = alert_n_q;

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);

	property p_ot_set;
		ot_q[1] |=> ot_flag_q ##1 (ot_flag_q || $past(clear_q));
	endproperty
	a_ot_set: assert property (p_ot_set) else $error("overheat not latched");

	property p_therm_rd;
		rd_req && cmd_q == `CMD_THERMAL |=>
			rd_data_q == {$past(ot_flag_q), 7'h00};
	endproperty
	a_therm_rd: assert property (p_therm_rd) else $error("bad thermal byte");

	property p_addr;
		wr_en && cmd_q == `REG_ADDR_CTRL |=>
			dev_addr[6:5] == `ADDR_FIXED && regs_q[I_ADDR] == $past(wr_data);
	endproperty
	a_addr: assert property (p_addr) else $error("address not updated");

	property p_sw_wr;
		wr_en && cmd_q == `REG_SW_CTRL |=> sw_ctrl_out == $past(wr_data);
	endproperty
	a_sw_wr: assert property (p_sw_wr) else $error("switch ctrl lost");

	property p_dis_off;
		!sw_byte[`DIS_BIT] |=> !discharge_on_out;
	endproperty
	a_dis_off: assert property (p_dis_off) else $error("discharge when off");

	property p_dis_end;
		dis_q && (vlow_q[1] || dis_cnt_q == DIS_LAST) |=> !dis_q [*2];
	endproperty
	a_dis_end: assert property (p_dis_end) else $error("discharge overran");

	property p_cc;
		##1 cc_q == clamp_cc($past(lim_byte)) && cc_q <= CC_MAX;
	endproperty
	a_cc: assert property (p_cc) else $error("bad current limit");

	property p_ldc;
		##1 {6'h00, ldc_q} == ($past(lim_byte) >= 8'h80 ? 8'h00 :
			$past(ldc_byte) & 8'h03);
	endproperty
	a_ldc: assert property (p_ldc) else $error("bad line drop");

	property p_load;
		loaded_q && !$past(loaded_q) |-> sw_byte == $past(otp_in.sw_ctrl);
	endproperty
	a_load: assert property (p_load) else $error("nvm not loaded");

	property p_clear;
		clear_q && !ot_q[1] |=> !ot_flag_q && alert_output_n_out;
	endproperty
	a_clear: assert property (p_clear) else $error("clear failed");

	property p_hold;
		ot_flag_q && !clear_q |=> ot_flag_q;
	endproperty
	a_hold: assert property (p_hold) else $error("fault bit dropped");

	property p_mask;
		ot_flag_q && $past(regs_q[I_MASK][`MASK_OT_BIT]) |->
			alert_output_n_out;
	endproperty
	a_mask: assert property (p_mask) else $error("masked alert");
endmodule : crb_top
`default_nettype wire

// file: dv/crb_i2c_host.sv
`timescale 1ns/1ps
`default_nettype none
module crb_i2c_host (
	input  wire logic       clk_in,
	input  wire logic       sda_in,
	output logic            scl_out,
	output logic            sda_out,
	output logic [7:0]      rd_out,
	output logic            rd_stb_out
);
	initial begin
		scl_out = 1'b1;
		sda_out = 1'b1;
		rd_out = 8'h00;
		rd_stb_out = 1'b0;
	end

	task automatic hw(input int n);
		repeat (n) @(negedge clk_in);
	endtask : hw

	// sda moves two clocks after scl falls so no false start or stop
	task automatic bitx(input logic b, output logic r);
		hw(2);
		sda_out = b;
		hw(6);
		scl_out = 1'b1;
		hw(4);
		r = sda_in;
		hw(4);
		scl_out = 1'b0;
	endtask : bitx

	// also serves as repeated start
	task automatic start();
		sda_out = 1'b1;
		hw(8);
		scl_out = 1'b1;
		hw(8);
		sda_out = 1'b0;
		hw(8);
		scl_out = 1'b0;
	endtask : start

	task automatic stop();
		hw(2);
		sda_out = 1'b0;
		hw(8);
		scl_out = 1'b1;
		hw(8);
		sda_out = 1'b1;
		hw(8);
	endtask : stop

	task automatic tx(input logic [7:0] v, output logic a);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bitx(v[i], r);
		end
		bitx(1'b1, r);
		a = ~r;
	endtask : tx

	task automatic rx(input logic last);
		logic       r;
		logic [7:0] v;
		for (int i = 0; i < 8; i++) begin
			bitx(1'b1, r);
			v = {v[6:0], r};
		end
		bitx(last, r);
		rd_out = v;
		rd_stb_out = 1'b1;
		hw(1);
		rd_stb_out = 1'b0;
	endtask : rx
endmodule : crb_i2c_host
`default_nettype wire

// file: dv/tb_converter_config_register_bank.sv
`timescale 1ns/1ps
`default_nettype none
module tb_converter_config_register_bank
	import crb_pkg::*;
;
	localparam int DCYC = 50;
	logic         clk = 1'b0;
	logic         rst = 1'b1;
	logic         scl, h_sda, sda, sda_o, oe, rd_stb;
	logic         oh = 1'b0;
	logic         sd = 1'b0;
	logic         vl = 1'b0;
	logic [7:0]   rd_b, slew, blank, v;
	logic [6:0]   cc;
	logic [6:0]   adr = 7'h67;
	logic [1:0]   ld;
	logic         dis, al_n, a;
	crb_otp_t     otp = '0;
	crb_sw_ctrl_t swc;
	integer       seed = 32'hb0fe54be;
	int           bad_count = 0;
	int           n_tests = 0;
	logic [7:0]   exq[$];
	logic [7:0]   cl[7] = '{8'h00, 8'h6b, 8'h6c, 8'h6d, 8'h7f, 8'hff, 8'h80};

	// open drain with pull-up
	assign sda = h_sda & (oe ? sda_o : 1'b1);

	initial begin
		forever #2.5 clk = ~clk;
	end

	crb_top #(.DISCHARGE_CYCLES(DCYC)) DUT (
		.clk_in(clk), .rst_in(rst), .scl_in(scl), .sda_in(sda),
		.sda_out(sda_o), .sda_oe_out(oe), .otp_in(otp),
		.overheat_in(oh), .shutdown_in(sd), .vout_low_in(vl),
		.sw_ctrl_out(swc), .cc_threshold_code_value_out(cc),
		.line_drop_setting_out(ld), .slew_ctrl_out(slew),
		.blank_ctrl_out(blank), .discharge_on_out(dis),
		.alert_output_n_out(al_n));

	crb_i2c_host host (.clk_in(clk), .sda_in(sda), .scl_out(scl),
		.sda_out(h_sda), .rd_out(rd_b), .rd_stb_out(rd_stb));

	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		n_tests++;
		if (g !== e) begin
			bad_count++;
			$display("[ERR] t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk

	task automatic give_verdict();
		$display("checks %0d, mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : give_verdict

	always @(posedge clk) begin
		if (rd_stb === 1'b1)
			chk(rd_b, exq.size() > 0 ? exq.pop_front() : 8'hxx);
	end

	task automatic wr(input logic [7:0] c, input logic [7:0] d, input bit wd);
		logic k;
		host.start();
		host.tx({adr, 1'b0}, k);
		chk({7'h0, k}, 8'h01);
		host.tx(c, k);
		if (wd)
			host.tx(d, k);
		host.stop();
	endtask : wr

	task automatic rd(input logic [7:0] c, input logic [7:0] e);
		logic k;
		exq.push_back(e);
		host.start();
		host.tx({adr, 1'b0}, k);
		host.tx(c, k);
		host.start();
		host.tx({adr, 1'b1}, k);
		host.rx(1'b1);
		host.stop();
	endtask : rd

	function automatic logic [7:0] clampc(input logic [7:0] x);
		return (x[6:0] > 7'h6c) ? 8'h6c : {1'b0, x[6:0]};
	endfunction : clampc

	initial begin
		otp.sw_ctrl = 8'($random(seed));
		otp.cc_limit = 8'($random(seed));
		otp.ldc = 8'($random(seed));
		otp.slew = 8'($random(seed));
		otp.addr_ctrl = 8'h07;
		repeat (5) @(negedge clk);
		chk(swc, 8'h2f);
		chk({1'b0, cc}, 8'h6c);
		chk({6'h0, dis, al_n}, 8'h01);
		rst = 1'b0;
		repeat (3) @(negedge clk);
		chk(swc, otp.sw_ctrl);
		chk({1'b0, cc}, clampc(otp.cc_limit));
		chk({6'h0, ld}, otp.cc_limit[7] ? 8'h00 : {6'h0, otp.ldc[1:0]});
		chk(slew, otp.slew);
		$display("test reset done");
		for (int i = 0; i < 4; i++) begin
			v = 8'($random(seed));
			v[6:5] = i[1:0];
			wr(8'hd0, v, 1'b1);
			chk(swc, v);
			rd(8'hd0, v);
		end
		$display("test switching control done");
		wr(8'hd2, 8'h03, 1'b1);
		foreach (cl[i]) begin
			wr(8'hd1, cl[i], 1'b1);
			rd(8'hd1, cl[i]);
			chk({1'b0, cc}, clampc(cl[i]));
			chk({6'h0, ld}, cl[i][7] ? 8'h00 : 8'h03);
		end
		rd(8'h55, 8'h00);
		$display("test current limit done");
		oh = 1'b1;
		repeat (8) @(negedge clk);
		chk({7'h0, al_n}, 8'h00);
		rd(8'h7d, 8'h80);
		oh = 1'b0;
		rd(8'h7d, 8'h80);
		wr(8'h03, 8'h00, 1'b0);
		rd(8'h7d, 8'h00);
		chk({7'h0, al_n}, 8'h01);
		oh = 1'b1;
		wr(8'h03, 8'h00, 1'b0);
		rd(8'h7d, 8'h80);
		oh = 1'b0;
		wr(8'h03, 8'h00, 1'b0);
		wr(8'hd8, 8'h80, 1'b1);
		oh = 1'b1;
		repeat (8) @(negedge clk);
		chk({7'h0, al_n}, 8'h01);
		rd(8'h7d, 8'h80);
		oh = 1'b0;
		$display("test thermal status done");
		wr(8'hd0, 8'h02, 1'b1);
		sd = 1'b1;
		repeat (6) @(negedge clk);
		chk({7'h0, dis}, 8'h01);
		vl = 1'b1;
		repeat (6) @(negedge clk);
		chk({7'h0, dis}, 8'h00);
		sd = 1'b0;
		vl = 1'b0;
		repeat (6) @(negedge clk);
		sd = 1'b1;
		repeat (30) @(negedge clk);
		chk({7'h0, dis}, 8'h01);
		repeat (DCYC) @(negedge clk);
		chk({7'h0, dis}, 8'h00);
		sd = 1'b0;
		wr(8'hd0, 8'h00, 1'b1);
		sd = 1'b1;
		repeat (6) @(negedge clk);
		chk({7'h0, dis}, 8'h00);
		sd = 1'b0;
		$display("test discharge done");
		v = 8'($random(seed));
		v[4] = 1'b1;
		wr(8'hd4, v, 1'b1);
		adr = {2'b11, v[4:0]};
		rd(8'hd4, v);
		chk(blank, v);
		host.start();
		host.tx({7'h67, 1'b0}, a);
		chk({7'h0, a}, 8'h00);
		host.stop();
		$display("test address done");
		give_verdict();
	end

	initial begin
		repeat (60000) @(posedge clk);
		bad_count++;
		give_verdict();
	end
endmodule : tb_converter_config_register_bank
`default_nettype wire
